// >>> shared/comparator_digital_control_pkg.sv
// constants shared by the comparator digital control block
package comparator_digital_control_pkg;
	localparam int NUM_CMP = 6; // comparators 0..5
	localparam int NUM_PROT = 5; // comparators 1..5
	localparam int NUM_FILT = 7; // six comparators plus trigger source
	localparam int EXT_FILT = 6; // filter on the trigger source
	localparam int SURGE_CMP = 4; // comparator with rising-edge interrupt
	localparam int SURGE_SLOT = 3; // its slot among comparators 1..5
	localparam int CNT_W = 9; // filter counter width, up to 256
	// register indices
	localparam logic [3:0] SYNC_TRIM_IDX = 4'h0;
	localparam logic [3:0] SYNC_CTRL_IDX = 4'h1;
	localparam logic [3:0] SYNC_DB_IDX = 4'h2;
	localparam logic [3:0] SYNC_DLY_IDX = 4'h3;
	localparam logic [3:0] PROT_TRIM_BASE = 4'h4;
	localparam logic [3:0] PROT_CTRL_BASE = 4'h9;
	localparam logic [3:0] NUM_PROT_REGS = 4'h5;
	// reset values
	localparam logic [6:0] SYNC_TRIM_RST = 7'h20;
	localparam logic [7:0] SYNC_CTRL_RST = 8'h04;
	localparam logic [6:0] PROT_TRIM_RST = 7'h10;
	// field positions
	localparam int RAW_BIT = 7;
	localparam int MODE_BIT = 6;
	localparam int REF_BIT = 5;
	localparam int EN_BIT = 7;
	localparam int VOD_BIT = 4;
	localparam int INV_BIT = 3;
	localparam int TRG_BIT = 4;
	localparam int SRC_BIT = 2;
	localparam int FCLK_BIT = 7;
	// writable bits
	localparam logic [7:0] SYNC_DB_MASK = 8'hbf;
	localparam logic [7:0] PROT_CTRL_MASK = 8'hef;
	// comparators whose interrupt fires on a rising edge
	localparam logic [5:0] RISE_EDGE_MASK = 6'h10;
	// debounce and delay encodings
	localparam logic [5:0] DB6_MAX_CODE = 6'h2f;
	localparam logic [8:0] DB6_MAX_CYC = 9'h030;
	localparam logic [8:0] DB3_UNIT = 9'h002;
	localparam logic [8:0] CNT_ONE = 9'h001;
	localparam logic [5:0] DLY_BYPASS = 6'h00;
	localparam logic [2:0] DB3_SHORTEST = 3'h1;
	// calibration reference codes
	localparam logic [1:0] SYNC_REF_POS = 2'b01;
	localparam logic [1:0] SYNC_REF_ZERO = 2'b11;
	typedef enum logic [1:0] {
		CAL_NEG = 2'b00,
		CAL_POS = 2'b01,
		CAL_ZERO = 2'b10
	} cal_src_e;
endpackage

// >>> rtl/comparator_digital_control.sv
// digital control, filtering and trigger logic of six comparators
// Operation
// RULE1: falling-edge interrupts, comparator 4 rising edge
// RULE2: raw output bit readable, positive above negative
// RULE3: per-comparator calibration mode bit, reset zero
// RULE4: trim values, six bits then five bits
// RULE5: comparator 0 enable bit powers it
// RULE6: trigger on single or every second falling
// RULE7: inversion bit before the filtered output
// RULE8: trigger source pin or comparator 0, reset one
// RULE9: comparator 0 calibration reference decode
// RULE10: filter clock system clock or half
// RULE11: trigger input debounce time, six-bit code
// RULE12: trigger delay time, same six-bit code
// RULE13: comparators 1-5 calibration reference bit
// RULE14: comparator 4 filtered output readable
// RULE15: comparator 4 debounce on system clock
// RULE16: comparator 4 enable powers comparator and converter
// RULE17: route trigger, comparator 0 and 4 outputs
// RULE18: comparators 1,2,3,5 three-bit debounce
// RULE19: filter updates after level held long enough
// RULE20: disabled comparator keeps filter and interrupt quiet
module comparator_digital_control
	import comparator_digital_control_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regRdData,
	input wire logic [5:0] rawResult,
	input wire logic pulseSyncPin,
	output logic [5:0] comparatorOn,
	output logic [5:0] trimMode,
	output logic [5:0] syncTrimValue,
	output logic [24:0] protectTrimValue,
	output logic [1:0] syncCalSource,
	output logic [4:0] protectTrimReference,
	output logic [5:0] filteredOutput,
	output logic [5:0] comparatorIrq,
	output logic syncCompToTimers,
	output logic surgeToAdc,
	output logic delayedSyncIrq
);

	// whole block state, registered in one place
	typedef struct packed {
		logic [6:0] syncTrim; // mode and six-bit trim
		logic [7:0] syncCtrl; // enable, hysteresis, trigger, invert, source, ref
		logic [7:0] syncDb; // filter clock select and debounce code
		logic [5:0] syncDly; // delay code
		logic [4:0][6:0] protTrim; // mode, reference, five-bit trim
		logic [4:0][7:0] protCtrl; // enable, hysteresis, invert, debounce
		logic [5:0] raw; // sampled comparator results
		logic [6:0] filt; // filter outputs
		logic [6:0][8:0] cnt; // filter counters
		logic halfTick; // half-rate filter clock phase
		logic pairOdd; // first falling edge of a pair seen
		logic dlyBusy; // delay counter running
		logic [8:0] dlyCnt; // delay elapsed ticks
		logic [5:0] irq; // interrupt pulses
		logic delayedIrq; // delayed trigger pulse
		logic [1:0] calSrc; // decoded comparator 0 reference
		logic [7:0] rdData; // read answer
	} state_s;

	state_s st; // current state
	state_s nx; // next state
	logic [5:0] on; // per-comparator enables
	logic [5:0] inv; // per-comparator inversion
	logic [6:0] filtIn; // filter inputs after inversion
	logic fclkTick; // filter clock enable this cycle
	logic trig; // accepted trigger edge

	// six-bit debounce or delay code to ticks; 11xxxx saturates
	function automatic logic [8:0] db6Cycles(input logic [5:0] code);
		logic [8:0] n;
		n = {3'h0, code};
		if (code > DB6_MAX_CODE) begin
			n = DB6_MAX_CYC;
		end
		return n;
	endfunction

	// three-bit debounce code to ticks: 4, 8 .. 256, zero bypasses
	function automatic logic [8:0] db3Cycles(input logic [2:0] code);
		logic [8:0] n;
		n = '0;
		if (code != 3'h0) begin
			n = 9'(DB3_UNIT << code);
		end
		return n;
	endfunction

	// hit flag and slot of an address inside a five-register group
	function automatic logic [3:0] protSlot(input logic [3:0] a, input logic [3:0] base);
		logic [3:0] s;
		s = '0;
		if (a >= base && a < 4'(base + NUM_PROT_REGS)) begin
			s = {1'b1, 3'(a - base)};
		end
		return s;
	endfunction

	// read mux; read-only bits come from live state
	function automatic logic [7:0] readReg(input state_s s, input logic [3:0] a);
		logic [3:0] tSlot;
		logic [3:0] cSlot;
		logic [7:0] d;
		tSlot = protSlot(a, PROT_TRIM_BASE);
		cSlot = protSlot(a, PROT_CTRL_BASE);
		d = '0;
		if (a == SYNC_TRIM_IDX) begin
			// RULE2: raw bit readback
			d = {s.raw[0], s.syncTrim};
		end else if (a == SYNC_CTRL_IDX) begin
			d = s.syncCtrl;
		end else if (a == SYNC_DB_IDX) begin
			d = s.syncDb;
		end else if (a == SYNC_DLY_IDX) begin
			d = {2'b00, s.syncDly};
		end else if (tSlot[3]) begin
			// RULE2: raw bit readback
			d = {s.raw[3'(tSlot[2:0] + 3'h1)], s.protTrim[tSlot[2:0]]};
		end else if (cSlot[3]) begin
			d = s.protCtrl[cSlot[2:0]];
			// RULE14: filtered output readback
			d[VOD_BIT] = s.filt[3'(cSlot[2:0] + 3'h1)];
		end
		return d;
	endfunction

	// enables and inversion gathered per comparator
	assign on[0] = st.syncCtrl[EN_BIT];
	assign inv[0] = st.syncCtrl[INV_BIT];
	for (genvar g = 0; g < NUM_PROT; g++) begin : gProt
		assign on[g + 1] = st.protCtrl[g][EN_BIT];
		assign inv[g + 1] = st.protCtrl[g][INV_BIT];
		assign trimMode[g + 1] = st.protTrim[g][MODE_BIT];
		assign protectTrimReference[g] = st.protTrim[g][REF_BIT];
		assign protectTrimValue[g * 5 +: 5] = st.protTrim[g][4:0];
	end

	// next-state logic
	always_comb begin
		logic [3:0] tSlot;
		logic [3:0] cSlot;
		logic [8:0] thr;
		logic tick;
		logic fall;
		tSlot = protSlot(regAddr, PROT_TRIM_BASE);
		cSlot = protSlot(regAddr, PROT_CTRL_BASE);
		thr = '0;
		tick = 1'b0;
		fall = 1'b0;
		nx = st;
		nx.rdData = '0;
		nx.irq = '0;
		nx.delayedIrq = 1'b0;
		nx.raw = rawResult;
		nx.halfTick = ~st.halfTick;
		trig = 1'b0;

		// register writes; read-only bits are never stored
		if (regWrite) begin
			if (regAddr == SYNC_TRIM_IDX) begin
				// RULE3: mode bit
				// RULE4: six-bit trim
				nx.syncTrim = regWrData[6:0];
			end else if (regAddr == SYNC_CTRL_IDX) begin
				nx.syncCtrl = regWrData;
			end else if (regAddr == SYNC_DB_IDX) begin
				nx.syncDb = regWrData & SYNC_DB_MASK;
			end else if (regAddr == SYNC_DLY_IDX) begin
				nx.syncDly = regWrData[5:0];
			end else if (tSlot[3]) begin
				// RULE13: reference bit
				// RULE4: five-bit trim
				nx.protTrim[tSlot[2:0]] = regWrData[6:0];
			end else if (cSlot[3]) begin
				nx.protCtrl[cSlot[2:0]] = regWrData & PROT_CTRL_MASK;
			end
		end

		// read answer, one cycle after the strobe
		if (regRead) begin
			nx.rdData = readReg(st, regAddr);
		end

		// RULE10: filter clock rate
		fclkTick = ~st.syncDb[FCLK_BIT] | st.halfTick;

		// RULE7: inversion ahead of the filters
		for (int i = 0; i < NUM_CMP; i++) begin
			filtIn[i] = st.raw[i] ^ inv[i];
		end
		// RULE8: trigger source select
		filtIn[EXT_FILT] = st.syncCtrl[SRC_BIT] ? (on[0] & filtIn[0]) : pulseSyncPin;

		// debounce filters
		for (int i = 0; i < NUM_FILT; i++) begin
			if (i == 0 || i == EXT_FILT) begin
				// RULE11: six-bit debounce code
				thr = db6Cycles(st.syncDb[5:0]);
				tick = fclkTick;
			end else if (i == SURGE_CMP) begin
				// RULE15: system clock debounce
				thr = db3Cycles(st.protCtrl[SURGE_SLOT][2:0]);
				tick = 1'b1;
			end else begin
				// RULE18: filter clock debounce
				thr = db3Cycles(st.protCtrl[i - 1][2:0]);
				tick = fclkTick;
			end
			if (thr == '0) begin
				nx.filt[i] = filtIn[i];
				nx.cnt[i] = '0;
			end else if (filtIn[i] == st.filt[i]) begin
				nx.cnt[i] = '0;
			end else if (tick) begin
				// RULE19: update only after the level held
				if (9'(st.cnt[i] + CNT_ONE) >= thr) begin
					nx.filt[i] = filtIn[i];
					nx.cnt[i] = '0;
				end else begin
					nx.cnt[i] = 9'(st.cnt[i] + CNT_ONE);
				end
			end
			// RULE5: comparator 0 off
			// RULE16: comparator 4 off
			// RULE20: disabled filter held low
			if (i < NUM_CMP && !on[i]) begin
				nx.filt[i] = 1'b0;
				nx.cnt[i] = '0;
			end
		end

		// RULE1: edge polarity per comparator
		for (int i = 0; i < NUM_CMP; i++) begin
			if (RISE_EDGE_MASK[i]) begin
				nx.irq[i] = on[i] & nx.filt[i] & ~st.filt[i];
			end else begin
				nx.irq[i] = on[i] & ~nx.filt[i] & st.filt[i];
			end
		end

		// RULE6: single or every second falling edge
		fall = st.filt[EXT_FILT] & ~nx.filt[EXT_FILT];
		if (!st.syncCtrl[TRG_BIT]) begin
			nx.pairOdd = 1'b0;
			trig = fall;
		end else if (fall) begin
			nx.pairOdd = ~st.pairOdd;
			trig = st.pairOdd;
		end

		// RULE12: trigger delay; a new trigger restarts it
		thr = db6Cycles(st.syncDly);
		if (trig) begin
			nx.dlyCnt = '0;
			nx.dlyBusy = (thr != '0);
			nx.delayedIrq = (thr == '0);
		end else if (st.dlyBusy && fclkTick) begin
			if (9'(st.dlyCnt + CNT_ONE) >= thr) begin
				nx.dlyBusy = 1'b0;
				nx.delayedIrq = 1'b1;
			end else begin
				nx.dlyCnt = 9'(st.dlyCnt + CNT_ONE);
			end
		end

		// RULE9: calibration reference decode
		if (nx.syncCtrl[1:0] == SYNC_REF_ZERO) begin
			nx.calSrc = CAL_ZERO;
		end else if (nx.syncCtrl[1:0] == SYNC_REF_POS) begin
			nx.calSrc = CAL_POS;
		end else begin
			nx.calSrc = CAL_NEG;
		end
	end

	// state register with synchronous reset
	always_ff @(posedge clk) begin
		if (srst) begin
			st <= '0;
			st.syncTrim <= SYNC_TRIM_RST;
			st.syncCtrl <= SYNC_CTRL_RST;
			for (int i = 0; i < NUM_PROT; i++) begin
				st.protTrim[i] <= PROT_TRIM_RST;
			end
		end else begin
			st <= nx;
		end
	end

	// outputs, all taken from state flops
	assign regRdData = st.rdData;
	assign comparatorOn = on;
	assign trimMode[0] = st.syncTrim[MODE_BIT];
	assign syncTrimValue = st.syncTrim[5:0];
	assign syncCalSource = st.calSrc;
	assign filteredOutput = st.filt[5:0];
	assign comparatorIrq = st.irq;
	// RULE17: internal consumers
	assign syncCompToTimers = st.filt[0];
	assign surgeToAdc = st.filt[SURGE_CMP];
	assign delayedSyncIrq = st.delayedIrq;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	// comparator 4 input steady high for the shortest debounce
	sequence surgeHeld;
		(filtIn[SURGE_CMP] && !st.filt[SURGE_CMP] && on[SURGE_CMP]
			&& st.protCtrl[SURGE_SLOT][2:0] == DB3_SHORTEST)[*4];
	endsequence

	// second edge of a pair with double-edge mode
	sequence pairClose;
		trig && st.syncCtrl[TRG_BIT];
	endsequence

	AST_SURGE_RISE: assert property (comparatorIrq[SURGE_CMP] |->  // RULE1
		filteredOutput[SURGE_CMP] && !$past(filteredOutput[SURGE_CMP]))
		else $error("comparator 4 interrupt without rising edge");
	AST_SYNC_FALL: assert property (comparatorIrq[0] |->  // RULE1
		!filteredOutput[0] && $past(filteredOutput[0]))
		else $error("comparator 0 interrupt without falling edge");
	AST_RAW_READ: assert property (regRead && regAddr == SYNC_TRIM_IDX |=>  // RULE2
		regRdData[RAW_BIT] == $past(st.raw[0]))
		else $error("raw result readback wrong");
	AST_MODE_WRITE: assert property (regWrite && regAddr == SYNC_TRIM_IDX |=>  // RULE3
		trimMode[0] == $past(regWrData[MODE_BIT]))
		else $error("calibration mode not stored");
	AST_OFF_QUIET: assert property (!comparatorOn[0] |=>  // RULE5
		!filteredOutput[0] && !comparatorIrq[0])
		else $error("disabled comparator 0 active");
	AST_PAIR: assert property (pairClose |-> st.pairOdd)  // RULE6
		else $error("double-edge trigger on first edge");
	AST_CAL_ZERO: assert property ((st.syncCtrl[1:0] == SYNC_REF_ZERO)[*2] |->  // RULE9
		syncCalSource == CAL_ZERO)
		else $error("zero reference not selected");
	AST_HALF_TICK: assert property (st.syncDb[FCLK_BIT] && $past(st.syncDb[FCLK_BIT]) |->  // RULE10
		fclkTick != $past(fclkTick))
		else $error("half-rate filter clock not alternating");
	AST_EXT_MAX: assert property ($changed(st.filt[EXT_FILT]) && st.syncDb[5:4] == 2'b11  // RULE11
		&& !st.syncDb[FCLK_BIT] && $past(st.syncDb, 47) == st.syncDb |->
		$past(filtIn[EXT_FILT], 47) == st.filt[EXT_FILT])
		else $error("trigger debounce shorter than maximum");
	AST_DLY_BYPASS: assert property (trig && st.syncDly == DLY_BYPASS |=>  // RULE12
		delayedSyncIrq)
		else $error("bypassed delay not immediate");
	AST_SURGE_DB: assert property (surgeHeld |=> filteredOutput[SURGE_CMP])  // RULE15
		else $error("comparator 4 debounce not four cycles");
	AST_SURGE_OFF: assert property (!comparatorOn[SURGE_CMP] |=>  // RULE16
		!surgeToAdc && !comparatorIrq[SURGE_CMP])
		else $error("disabled comparator 4 active");
	AST_PROT_OFF: assert property (!comparatorOn[1] |=>  // RULE20
		!filteredOutput[1] && !comparatorIrq[1])
		else $error("disabled comparator 1 active");

endmodule

// >>> testbench/comparator_core_model.sv
// behavioural model of the six analog comparator cores
module comparator_core_model (
	input wire logic clk,
	input wire logic [5:0] comparatorOn,
	input wire logic [5:0] posAboveNeg,
	output logic [5:0] rawResult
);
	timeunit 1ns;
	timeprecision 1ps;
	// unpowered cores give no usable result, so they toggle every cycle
	logic [5:0] noise_reg = 6'h2a;
	always_ff @(posedge clk) begin
		noise_reg <= ~noise_reg;
	end
	// result follows the commanded input relation only while powered
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			rawResult[i] = comparatorOn[i] ? posAboveNeg[i] : noise_reg[i];
		end
	end
endmodule

// >>> testbench/tb_comparator_digital_control.sv
// self-checking bench for the comparator digital control block
module tb_comparator_digital_control
	import comparator_digital_control_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [3:0] regAddr = 4'h0;
	logic [7:0] regWrData = 8'h00;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [7:0] regRdData, rdVal;
	logic [5:0] rawResult, comparatorOn, trimMode, syncTrimValue, filteredOutput, comparatorIrq;
	logic [5:0] posAboveNeg = 6'h00; // commanded analog relation per core
	logic pulseSyncPin = 1'b1; // pin idles high
	logic [24:0] protectTrimValue;
	logic [1:0] syncCalSource;
	logic [4:0] protectTrimReference;
	logic syncCompToTimers, surgeToAdc, delayedSyncIrq;
	int errors = 0;
	int check_count = 0;
	int cycles = 0;
	always #5 clk = ~clk;
	comparator_digital_control u_dut (.clk(clk), .srst(srst), .regAddr(regAddr),
		.regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
		.regRdData(regRdData), .rawResult(rawResult), .pulseSyncPin(pulseSyncPin),
		.comparatorOn(comparatorOn), .trimMode(trimMode), .syncTrimValue(syncTrimValue),
		.protectTrimValue(protectTrimValue), .syncCalSource(syncCalSource),
		.protectTrimReference(protectTrimReference), .filteredOutput(filteredOutput),
		.comparatorIrq(comparatorIrq), .syncCompToTimers(syncCompToTimers),
		.surgeToAdc(surgeToAdc), .delayedSyncIrq(delayedSyncIrq));
	comparator_core_model u_cores (.clk(clk), .comparatorOn(comparatorOn),
		.posAboveNeg(posAboveNeg), .rawResult(rawResult));
	task automatic final_report();
		$display("errors=%0d checks=%0d", errors, check_count);
		if (errors == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// hang guard, far above the fewer than a thousand cycles the run needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			final_report();
		end
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	// one-cycle write strobe; next call waits a fresh edge
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		regWrite <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk);
		regWrite <= 1'b0;
		// let the landing edge settle before callers look at outputs
		#1;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a);
		@(posedge clk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRead <= 1'b0;
		#1;
		rdVal = regRdData;
	endtask
	task automatic drv(input int i, input logic v);
		@(posedge clk);
		posAboveNeg[i] <= v;
	endtask
	task automatic pin(input logic v);
		@(posedge clk);
		pulseSyncPin <= v;
	endtask
	// slot 6 stands for the delayed trigger pulse
	function automatic logic watched(input int sel);
		return (sel < 6) ? filteredOutput[sel] : delayedSyncIrq;
	endfunction
	function automatic int ticks(input logic [5:0] c);
		return (c[5:4] == 2'b11) ? 48 : int'(c);
	endfunction
	// counts cycles until the watched bit reaches target, bounded
	task automatic settle(input int sel, input logic target, input int lo, input int hi);
		int n;
		n = 0;
		while (watched(sel) !== target && n < 600) begin
			@(posedge clk);
			#1;
			n++;
		end
		check($sformatf("latency slot %0d is %0d", sel, n), n >= lo && n <= hi, 1);
	endtask
	task automatic quiet(input int sel, input int n);
		repeat (n) begin
			@(posedge clk);
			#1;
			check("quiet", {watched(sel), (sel < 6) ? comparatorIrq[sel] : 1'b0}, 2'b00);
		end
	endtask
	// reset values of every index, unmapped ones included
	task automatic test_reset();
		check("sync trim", syncTrimValue, 6'h20);
		check("protect trim", protectTrimValue, {5{5'h10}});
		for (int a = 0; a < 16; a++) begin
			rd(a[3:0]);
			check($sformatf("reset reg %0d", a), rdVal & ((a == 0 || (a > 3 && a < 9)) ?
				8'h7f : 8'hff), a == 0 ? 8'h20 : a == 1 ? 8'h04 :
				(a > 3 && a < 9) ? 8'h10 : 8'h00);
		end
	endtask
	// writable and read-only bits, trim outputs
	task automatic test_regs();
		wr(4'h0, 8'hff);
		wr(4'h2, 8'hff);
		wr(4'h3, 8'hff);
		wr(4'h7, 8'hff);
		wr(4'he, 8'hff);
		rd(4'h0);
		check("trim reg", rdVal & 8'h7f, 8'h7f);
		rd(4'h2);
		check("debounce reg", rdVal, 8'hbf);
		rd(4'h3);
		check("delay reg", rdVal, 8'h3f);
		rd(4'he);
		check("unmapped", rdVal, 8'h00);
		check("sync trim", syncTrimValue, 6'h3f);
		check("modes", trimMode, 6'h11);
		check("c4 trim", protectTrimValue[15+:5], 5'h1f);
		check("c4 ref", protectTrimReference, 5'h08);
		wr(4'h0, 8'h20);
		wr(4'h2, 8'h00);
		wr(4'h3, 8'h00);
		wr(4'h7, 8'h10);
		// every reference code of comparator 0
		for (int c = 0; c < 4; c++) begin
			wr(4'h1, 8'h04 | c[7:0]);
			check("cal src", syncCalSource, c == 3 ? 2'b10 : c == 1 ? 2'b01 : 2'b00);
		end
	endtask
	task automatic test_raw();
		wr(4'ha, 8'h80);
		drv(2, 1'b1);
		repeat (2) @(posedge clk);
		rd(4'h5);
		check("raw high", rdVal[7], 1'b1);
		drv(2, 1'b0);
		repeat (2) @(posedge clk);
		rd(4'h5);
		check("raw low", rdVal[7], 1'b0);
		wr(4'ha, 8'h00);
		quiet(2, 16);
	endtask
	// rising-edge interrupt and system-clock debounce steps
	task automatic test_surge();
		int lat;
		wr(4'hc, 8'h80);
		check("power", comparatorOn, 6'h10);
		for (int c = 0; c < 5; c++) begin
			wr(4'hc, 8'h80 | c[7:0]);
			lat = (c == 0) ? 2 : (1 << (c + 1)) + 1;
			drv(4, 1'b1);
			settle(4, 1'b1, lat, lat);
			check("rise irq", comparatorIrq[4], 1'b1);
			check("to adc", surgeToAdc, 1'b1);
			drv(4, 1'b0);
			settle(4, 1'b0, lat, lat);
			check("fall irq", comparatorIrq[4], 1'b0);
		end
		wr(4'hc, 8'h88);
		settle(4, 1'b1, 0, 4);
		check("inv irq", comparatorIrq[4], 1'b1);
		rd(4'hc);
		check("surge reg", rdVal, 8'h98);
		wr(4'hc, 8'h08);
		settle(4, 1'b0, 0, 4);
		quiet(4, 4);
	endtask
	// falling-edge interrupt, filter clock full and half rate
	task automatic test_protect();
		wr(4'h9, 8'h81);
		drv(1, 1'b1);
		settle(1, 1'b1, 5, 5);
		check("rise irq", comparatorIrq[1], 1'b0);
		drv(1, 1'b0);
		settle(1, 1'b0, 5, 5);
		check("fall irq", comparatorIrq[1], 1'b1);
		wr(4'h2, 8'h80);
		drv(1, 1'b1);
		settle(1, 1'b1, 8, 10);
		drv(1, 1'b0);
		settle(1, 1'b0, 8, 10);
		wr(4'h2, 8'h00);
		wr(4'h9, 8'h00);
	endtask
	// pin source with debounce and delay codes, then double-edge mode
	task automatic test_trigger_pin();
		logic [5:0] db [6] = '{6'h00, 6'h03, 6'h2f, 6'h30, 6'h00, 6'h00};
		logic [5:0] dly [6] = '{6'h00, 6'h00, 6'h00, 6'h00, 6'h05, 6'h3f};
		int t;
		wr(4'h1, 8'h00);
		for (int k = 0; k < 6; k++) begin
			wr(4'h2, {2'b00, db[k]});
			wr(4'h3, {2'b00, dly[k]});
			// a bypassed debounce still costs the filter flop's cycle
			t = ticks(db[k]) + ticks(dly[k]) + ((db[k] == 6'h00) ? 1 : 0);
			pin(1'b0);
			settle(6, 1'b1, t, t + 2);
			pin(1'b1);
			repeat (60) @(posedge clk);
		end
		wr(4'h2, 8'h00);
		wr(4'h3, 8'h00);
		wr(4'h1, 8'h10);
		pin(1'b0);
		quiet(6, 8);
		pin(1'b1);
		repeat (4) @(posedge clk);
		pin(1'b0);
		settle(6, 1'b1, 1, 3);
		pin(1'b1);
	endtask
	// comparator 0 as trigger source and timer feed
	task automatic test_trigger_comp0();
		wr(4'h1, 8'h84);
		check("c0 power", comparatorOn, 6'h01);
		drv(0, 1'b1);
		settle(0, 1'b1, 1, 4);
		check("to timers", syncCompToTimers, 1'b1);
		drv(0, 1'b0);
		settle(0, 1'b0, 1, 4);
		check("c0 irq", comparatorIrq[0], 1'b1);
		settle(6, 1'b1, 0, 3);
	endtask
	initial begin
		repeat (8) @(posedge clk);
		// reads answer zero while reset holds, so release it first
		srst <= 1'b0;
		test_reset();
		test_regs();
		test_raw();
		test_surge();
		test_protect();
		test_trigger_pin();
		test_trigger_comp0();
		final_report();
	end
endmodule
